// [design/ocd_top.sv]
// Output channel dividers for pairs B and C with their APB register file
//
// How it works
// [R1] Output stays low for the low count plus one source cycles.
// [R2] Output stays high for the high count plus one source cycles.
// [R3] Bypass parks the divider and passes its source clock; channel C resets bypassed.
// [R4] Sync-ignore clear obeys the chip sync; set ignores it.
// [R5] Force level is static high when set, needs sync-ignore set too.
// [R6] Start bit picks the output level the divider begins with.
// [R7] Each divider has a four-bit phase offset resetting to zero.
// [R8] Direct route drives the pair from VCO (10b), clock input (00b), else divider.
// [R9] Duty correction disable bit turns correction off; clear means correction active.
// [R10] Second divider feeds pair B, third divider feeds pair C, both pins each.
// [R11] After an obeyed sync the first edge waits the phase offset in source cycles.
// [R12] Divided period equals low plus high durations, ratios two to thirty-two.
`timescale 1ns/100ps
module ocd_top #(
	parameter int SYNC_STAGES = ocd_pkg::SYNC_DEPTH
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ocd_pkg::ADDR_W-1:0] paddr,
	input wire logic [ocd_pkg::DATA_W-1:0] pwdata,
	output logic [ocd_pkg::DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic vco_in,
	input wire logic clk_in,
	input wire logic chip_sync_n,
	output logic pair_b_out_p,
	output logic pair_b_out_n,
	output logic pair_c_out_p,
	output logic pair_c_out_n,
	output logic [ocd_pkg::NUM_CH-1:0] duty_correction_disable
);

	// Fewer than two stages would let logic read a metastable flop
	if (SYNC_STAGES < 2) begin : g_bad_sync
		$error("ocd_top: SYNC_STAGES must be at least 2");
	end

	// Whole state of the block
	typedef struct packed {
		ocd_pkg::ocd_counts_s [ocd_pkg::NUM_CH-1:0] counts;
		ocd_pkg::ocd_ctl_b_s [ocd_pkg::NUM_CH-1:0] ctl_b;
		ocd_pkg::ocd_ctl_c_s [ocd_pkg::NUM_CH-1:0] ctl_c;
		logic [1:0] src_sel;
		logic [SYNC_STAGES:0] vco_sy;
		logic [SYNC_STAGES:0] clk_sy;
		logic [SYNC_STAGES-1:0] sync_sy;
		logic [ocd_pkg::DATA_W-1:0] prdata;
		logic pready;
		logic pslverr;
		logic [ocd_pkg::NUM_CH-1:0] out_p;
		logic [ocd_pkg::NUM_CH-1:0] out_n;
		logic [ocd_pkg::NUM_CH-1:0] dcc_off;
	} ocd_top_s;

	ocd_top_s s_r;
	ocd_top_s s_nxt;

	logic [ocd_pkg::NUM_CH-1:0] div_out;
	logic vco_lvl;
	logic clk_lvl;
	logic src_lvl;
	logic src_rise;
	logic sync_hold;
	logic [9:0] idx;
	logic access;
	logic wr_now;

	// Only the last synchroniser stages are looked at
	assign vco_lvl = s_r.vco_sy[SYNC_STAGES-1];
	assign clk_lvl = s_r.clk_sy[SYNC_STAGES-1];
	assign sync_hold = ~s_r.sync_sy[SYNC_STAGES-1]; // [R4]

	// Divider source: clock input on 00b, VCO path otherwise
	assign src_lvl = (s_r.src_sel == ocd_pkg::SRC_CLK) ? clk_lvl : vco_lvl;
	assign src_rise = (s_r.src_sel == ocd_pkg::SRC_CLK) ?
		(clk_lvl & ~s_r.clk_sy[SYNC_STAGES]) :
		(vco_lvl & ~s_r.vco_sy[SYNC_STAGES]);

	// Bus decode; one wait state, write lands when pready is seen high
	assign idx = paddr[ocd_pkg::ADDR_W-1:2];
	assign access = psel & penable;
	assign wr_now = access & s_r.pready & pwrite;

	// One divider per channel: index 0 drives pair B, index 1 drives pair C
	for (genvar i = 0; i < ocd_pkg::NUM_CH; i++) begin : g_ch
		ocd_div #(
			.CNT_W(ocd_pkg::CNT_W)
		) u_div (
			.pclk(pclk),
			.presetn(presetn),
			.src_rise(src_rise),
			.src_lvl(src_lvl),
			.counts(s_r.counts[i]),
			.ctl(s_r.ctl_b[i]),
			.sync_hold(sync_hold),
			.div_out(div_out[i])
		);
	end

	// Next state of synchronisers, registers, bus answer and outputs
	always_comb begin
		logic [ocd_pkg::DATA_W-1:0] rd;
		logic hit;
		logic routed;
		rd = '0;
		hit = 1'b1;
		routed = 1'b0;
		s_nxt = s_r;

		// Pin inputs pass a flop chain before anything reads them
		s_nxt.vco_sy = {s_r.vco_sy[SYNC_STAGES-1:0], vco_in};
		s_nxt.clk_sy = {s_r.clk_sy[SYNC_STAGES-1:0], clk_in};
		s_nxt.sync_sy = {s_r.sync_sy[SYNC_STAGES-2:0], chip_sync_n};

		// Read mux; unmapped words read zero and flag an error
		case (idx)
			ocd_pkg::IDX_CH1_COUNTS: rd[7:0] = s_r.counts[0];
			ocd_pkg::IDX_CH1_CTL_B: rd[7:0] = s_r.ctl_b[0];
			ocd_pkg::IDX_CH1_CTL_C: rd[7:0] = s_r.ctl_c[0];
			ocd_pkg::IDX_CH2_COUNTS: rd[7:0] = s_r.counts[1];
			ocd_pkg::IDX_CH2_CTL_B: rd[7:0] = s_r.ctl_b[1];
			ocd_pkg::IDX_CH2_CTL_C: rd[7:0] = s_r.ctl_c[1];
			ocd_pkg::IDX_SRC_SEL: rd[1:0] = s_r.src_sel;
			ocd_pkg::IDX_STATUS: begin
				rd[ocd_pkg::STAT_OUT_LSB +: ocd_pkg::NUM_CH] = div_out;
				rd[ocd_pkg::STAT_SYNC_BIT] = sync_hold;
			end
			default: hit = 1'b0;
		endcase

		// Answer registered in the first access cycle, dropped after the handshake
		s_nxt.pready = access & ~s_r.pready;
		if (access & ~s_r.pready) begin
			s_nxt.prdata = pwrite ? '0 : rd;
			s_nxt.pslverr = ~hit;
		end else begin
			s_nxt.prdata = '0;
			s_nxt.pslverr = 1'b0;
		end

		// Writes; status is read-only and ignores them
		if (wr_now) begin
			case (idx)
				ocd_pkg::IDX_CH1_COUNTS: s_nxt.counts[0] = pwdata[7:0]; // [R1] [R2]
				ocd_pkg::IDX_CH1_CTL_B: s_nxt.ctl_b[0] = pwdata[7:0];
				ocd_pkg::IDX_CH1_CTL_C: s_nxt.ctl_c[0] = pwdata[7:0] & ocd_pkg::CTL_C_MASK;
				ocd_pkg::IDX_CH2_COUNTS: s_nxt.counts[1] = pwdata[7:0]; // [R1] [R2]
				ocd_pkg::IDX_CH2_CTL_B: s_nxt.ctl_b[1] = pwdata[7:0];
				ocd_pkg::IDX_CH2_CTL_C: s_nxt.ctl_c[1] = pwdata[7:0] & ocd_pkg::CTL_C_MASK;
				ocd_pkg::IDX_SRC_SEL: s_nxt.src_sel = pwdata[1:0];
				default: ;
			endcase
		end

		// Output routing per pair; both pins share their divider
		for (int i = 0; i < ocd_pkg::NUM_CH; i++) begin
			routed = div_out[i]; // [R10]
			if (s_r.ctl_c[i].direct) begin
				if (s_r.src_sel == ocd_pkg::SRC_VCO) begin
					routed = vco_lvl; // [R8]
				end else if (s_r.src_sel == ocd_pkg::SRC_CLK) begin
					routed = clk_lvl; // [R8]
				end
			end
			s_nxt.out_p[i] = routed; // [R10]
			s_nxt.out_n[i] = ~routed; // [R10]
			// Correction itself lives in the output stage; the bit is passed there
			s_nxt.dcc_off[i] = s_r.ctl_c[i].dcc_off; // [R9]
		end
	end

	// State register; sync chain resets to the idle high level
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_r <= '0;
			s_r.counts[0] <= ocd_pkg::RST_COUNTS; // [R1] [R2]
			s_r.counts[1] <= ocd_pkg::RST_COUNTS;
			s_r.ctl_b[0] <= ocd_pkg::RST_CH1_CTL_B; // [R7]
			s_r.ctl_b[1] <= ocd_pkg::RST_CH2_CTL_B; // [R3]
			s_r.ctl_c[0] <= ocd_pkg::RST_CTL_C; // [R9]
			s_r.ctl_c[1] <= ocd_pkg::RST_CTL_C;
			s_r.src_sel <= ocd_pkg::RST_SRC_SEL;
			s_r.sync_sy <= '1;
			s_r.out_n <= '1;
		end else begin
			s_r <= s_nxt;
		end
	end

	// Every output straight from a flop
	assign prdata = s_r.prdata;
	assign pready = s_r.pready;
	assign pslverr = s_r.pslverr;
	assign pair_b_out_p = s_r.out_p[0];
	assign pair_b_out_n = s_r.out_n[0];
	assign pair_c_out_p = s_r.out_p[1];
	assign pair_c_out_n = s_r.out_n[1];
	assign duty_correction_disable = s_r.dcc_off;

endmodule

// [design/ocd_pkg.sv]
// Package with register map, field layouts, codes and reset values of the output channel dividers
package ocd_pkg;

	// Bus geometry, channel count, count width and sync depth
	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;
	localparam int NUM_CH = 2;
	localparam int CNT_W = 4;
	localparam int SYNC_DEPTH = 2;

	// Register indices; the byte address on the bus is four times the index
	localparam logic [9:0] IDX_CH1_COUNTS = 10'h193;
	localparam logic [9:0] IDX_CH1_CTL_B = 10'h194;
	localparam logic [9:0] IDX_CH1_CTL_C = 10'h195;
	localparam logic [9:0] IDX_CH2_COUNTS = 10'h196;
	localparam logic [9:0] IDX_CH2_CTL_B = 10'h197;
	localparam logic [9:0] IDX_CH2_CTL_C = 10'h198;
	localparam logic [9:0] IDX_SRC_SEL = 10'h1e1;
	localparam logic [9:0] IDX_STATUS = 10'h1f0;

	// Values after reset
	localparam logic [7:0] RST_COUNTS = 8'h00;
	localparam logic [7:0] RST_CH1_CTL_B = 8'h00;
	localparam logic [7:0] RST_CH2_CTL_B = 8'h80;
	localparam logic [7:0] RST_CTL_C = 8'h00;
	localparam logic [1:0] RST_SRC_SEL = 2'h2;

	// Writable bits of the control C and source select registers
	localparam logic [7:0] CTL_C_MASK = 8'h03;
	localparam logic [7:0] SRC_SEL_MASK = 8'h03;

	// Source select codes
	localparam logic [1:0] SRC_CLK = 2'h0;
	localparam logic [1:0] SRC_DIVIDED = 2'h1;
	localparam logic [1:0] SRC_VCO = 2'h2;

	// Status register bit positions
	localparam int STAT_OUT_LSB = 0;
	localparam int STAT_SYNC_BIT = 2;

	// Counts register: low count in the upper nibble, high count in the lower
	typedef struct packed {
		logic [3:0] lo;
		logic [3:0] hi;
	} ocd_counts_s;

	// Control B register
	typedef struct packed {
		logic bypass;
		logic nosync;
		logic force_hi;
		logic start_hi;
		logic [3:0] phase;
	} ocd_ctl_b_s;

	// Control C register
	typedef struct packed {
		logic [5:0] rsvd;
		logic direct;
		logic dcc_off;
	} ocd_ctl_c_s;

	typedef enum logic [1:0] {DIV_HOLD, DIV_DELAY, DIV_RUN} ocd_div_st_e;

	// Whole state of one divider
	typedef struct packed {
		ocd_div_st_e st;
		logic [3:0] cnt;
		logic lvl;
	} ocd_div_s;

endpackage

// [design/ocd_div.sv]
// One output channel divider counting rising edges of its source clock
`timescale 1ns/100ps
module ocd_div #(
	parameter int CNT_W = 4
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic src_rise,
	input wire logic src_lvl,
	input ocd_pkg::ocd_counts_s counts,
	input ocd_pkg::ocd_ctl_b_s ctl,
	input wire logic sync_hold,
	output logic div_out
);

	// Count fields are fixed at four bits by the register layout
	if (CNT_W != ocd_pkg::CNT_W) begin : g_bad_width
		$error("ocd_div: CNT_W must match the count field width");
	end

	ocd_pkg::ocd_div_s s_r;
	ocd_pkg::ocd_div_s s_nxt;

	// Next state: bypass, forced level, sync hold, then counting
	always_comb begin
		s_nxt = s_r;
		if (ctl.bypass) begin
			// Counters parked, source level copied through
			s_nxt.st = ocd_pkg::DIV_HOLD; // [R3]
			s_nxt.cnt = 4'h0;
			s_nxt.lvl = src_lvl; // [R3]
		end else if (ctl.nosync && ctl.force_hi) begin
			s_nxt.st = ocd_pkg::DIV_HOLD;
			s_nxt.cnt = 4'h0;
			s_nxt.lvl = 1'b1; // [R5]
		end else if (sync_hold && !ctl.nosync) begin
			// Held at the start level while sync is asserted
			s_nxt.st = ocd_pkg::DIV_HOLD; // [R4]
			s_nxt.cnt = 4'h0;
			s_nxt.lvl = ctl.start_hi; // [R6]
		end else begin
			unique case (s_r.st)
				ocd_pkg::DIV_HOLD: begin
					// Release: wait out the phase offset first
					s_nxt.st = ocd_pkg::DIV_DELAY;
					s_nxt.cnt = ctl.phase; // [R7] [R11]
					s_nxt.lvl = ctl.start_hi; // [R6]
				end
				ocd_pkg::DIV_DELAY: begin
					if (src_rise) begin
						if (s_r.cnt == 4'h0) begin
							s_nxt.st = ocd_pkg::DIV_RUN;
							s_nxt.cnt = ctl.start_hi ? counts.hi : counts.lo;
						end else begin
							s_nxt.cnt = s_r.cnt - 4'h1; // [R11]
						end
					end
				end
				ocd_pkg::DIV_RUN: begin
					// Each level lasts its count plus one source cycles
					if (src_rise) begin
						if (s_r.cnt == 4'h0) begin
							s_nxt.lvl = ~s_r.lvl;
							s_nxt.cnt = s_r.lvl ? counts.lo : counts.hi; // [R1] [R2] [R12]
						end else begin
							s_nxt.cnt = s_r.cnt - 4'h1;
						end
					end
				end
				default: begin
					s_nxt.st = ocd_pkg::DIV_HOLD;
				end
			endcase
		end
	end

	// State register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign div_out = s_r.lvl;

endmodule

// [bench/ocd_asserts.sv]
// Concurrent checks on the bus and pair pins of the output channel dividers
`timescale 1ns/100ps
module ocd_asserts (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ocd_pkg::ADDR_W-1:0] paddr,
	input wire logic [ocd_pkg::DATA_W-1:0] pwdata,
	input wire logic [ocd_pkg::DATA_W-1:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic vco_in,
	input wire logic clk_in,
	input wire logic chip_sync_n,
	input wire logic pair_b_out_p,
	input wire logic pair_b_out_n,
	input wire logic pair_c_out_p,
	input wire logic pair_c_out_n,
	input wire logic [ocd_pkg::NUM_CH-1:0] duty_correction_disable
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Bus steps; the answer lands in the second access cycle
	sequence s_setup; psel && !penable; endsequence
	sequence s_miss; psel && !penable && paddr == 12'h000; endsequence
	sequence s_answer; !pready ##1 pready; endsequence
	sequence s_wr_c; psel && penable && pready && pwrite && paddr == 12'h660; endsequence
	bus_answer_a: assert property (s_setup |=> s_answer) else $error("pready late");
	pulse_once_a: assert property (pready |=> !pready) else $error("pready held");
	err_ready_a: assert property (pslverr |-> pready && prdata == '0) else $error("bad error");
	idle_data_a: assert property (!pready |-> prdata == '0) else $error("idle data");
	unmapped_err_a: assert property (s_miss |=> ##1 pslverr) else $error("no error");
	pair_b_comp_a: assert property (pair_b_out_n == !pair_b_out_p) else $error("pair b");
	pair_c_comp_a: assert property (pair_c_out_n == !pair_c_out_p) else $error("pair c");
	dcc_follow_a: assert property (s_wr_c |=> ##1 duty_correction_disable[1] == $past(pwdata[0], 2))
		else $error("dcc c");
endmodule

bind ocd_top ocd_asserts ocd_asserts_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
	.pready, .pslverr, .vco_in, .clk_in, .chip_sync_n, .pair_b_out_p, .pair_b_out_n, .pair_c_out_p,
	.pair_c_out_n, .duty_correction_disable);

// [bench/tb.sv]
// Register and divider output tests for the output channel dividers
`timescale 1ns/100ps
module tb;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, vco_in = 0, clk_in = 0, chip_sync_n = 1;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, rd;
	logic pready, pslverr, er, bp, bn, cp, cn;
	logic [1:0] dcc;
	int bad_count = 0, checks = 0, ph = 0, h, l, d0, d3;
	logic [11:0] ra[7] = '{12'h64c, 12'h650, 12'h654, 12'h658, 12'h65c, 12'h660, 12'h784};
	logic [31:0] rv[7] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h80, 32'h0, 32'h2};
	ocd_top ocd_top_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .vco_in, .clk_in, .chip_sync_n, .pair_b_out_p(bp), .pair_b_out_n(bn), .pair_c_out_p(cp),
		.pair_c_out_n(cn), .duty_correction_disable(dcc));
	always #20 pclk = ~pclk;
	// Slow sources kept well under half of pclk: vco 6 cycles, clk 8
	always @(posedge pclk) begin
		ph <= ph + 1;
		vco_in <= (ph % 6) < 3;
		clk_in <= (ph % 8) < 4;
	end
	task chk(input string s, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e) begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", s, e, g);
		end
	endtask
	// One APB transfer, held until pready is sampled high
	task apb(input logic w, input logic [11:0] a, input logic [31:0] v);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= v;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		chk("pready", 1, pready);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// High and low spans of a pair, starting at a rise
	// Automatic so that the edge list starts empty on every call
	task automatic meas(input logic c);
		logic p, v;
		int n;
		int e[$];
		p = c ? cp : bp;
		for (n = 0; n < 300 && e.size() < 3; n++) begin
			@(posedge pclk);
			v = c ? cp : bp;
			if (v !== p && (e.size() > 0 || v === 1'b1))
				e.push_back(n);
			p = v;
		end
		h = e[1] - e[0];
		l = e[2] - e[1];
	endtask
	task span(input logic c, input int eh, input int el);
		meas(c);
		meas(c);
		chk("high span", eh, h);
		chk("low span", el, l);
	endtask
	// Cycles from sync release to the first rise; release aligned to the vco
	task syn(input logic [7:0] b, output int d);
		apb(1, 12'h650, b);
		chip_sync_n <= 1'b0;
		repeat (12) @(posedge pclk);
		while (ph % 6 != 0)
			@(posedge pclk);
		chip_sync_n <= 1'b1;
		for (d = 0; d < 300 && bp !== 1'b1; d++)
			@(posedge pclk);
	endtask
	task finish_test;
		$display("checks %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial begin
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		foreach (ra[i]) begin
			apb(0, ra[i], 0);
			chk("reset value", rv[i], rd);
		end
		apb(0, 12'h000, 0);
		chk("unmapped error", 1, er);
		$display("done registers");
		span(1, 3, 3);
		apb(1, 12'h64c, 32'h12);
		span(0, 18, 12);
		apb(1, 12'h784, 32'h0);
		span(0, 24, 16);
		span(1, 4, 4);
		$display("done dividing");
		apb(1, 12'h654, 32'h2);
		span(0, 4, 4);
		apb(1, 12'h784, 32'h1);
		span(0, 18, 12);
		apb(1, 12'h784, 32'h2);
		span(0, 3, 3);
		apb(1, 12'h654, 32'h0);
		apb(1, 12'h660, 32'h1);
		repeat (2) @(posedge pclk);
		chk("dcc", 2'b10, dcc);
		$display("done routing");
		apb(1, 12'h650, 32'h10);
		chip_sync_n <= 1'b0;
		repeat (30) @(posedge pclk);
		chk("start high", 1, bp);
		apb(1, 12'h650, 32'h60);
		repeat (30) @(posedge pclk);
		chk("forced", 1, bp);
		// Status: forced divider level in bit 0, sync still held in bit 2
		apb(0, 12'h7c0, 0);
		chk("status", 32'h5, rd & 32'h5);
		apb(1, 12'h650, 32'h40);
		span(0, 18, 12);
		chip_sync_n <= 1'b1;
		syn(8'h00, d0);
		syn(8'h03, d3);
		chk("phase delay", 18, d3 - d0);
		$display("done sync");
		finish_test();
	end
	// Watchdog well past the expected run of about a thousand cycles
	initial begin
		#400000;
		bad_count++;
		finish_test();
	end
endmodule
